// >>> core/crbdth_pkg.sv
/*
 * Shared constants and types of the CAN message handler block.
 * Assumes a single 100 MHz clock and the plain register port.
 */
package crbdth_pkg;
	localparam logic [7:0] CRBDTH_NDAT_LO_OFS  = 8'h00;
	localparam logic [7:0] CRBDTH_NDAT_HI_OFS  = 8'h04;
	localparam logic [7:0] CRBDTH_CTRL_OFS     = 8'h08;
	localparam logic [7:0] CRBDTH_RXCFG_OFS    = 8'h0C;
	localparam logic [7:0] CRBDTH_TXCFG_OFS    = 8'h10;
	localparam logic [7:0] CRBDTH_TXADD_OFS    = 8'h14;
	localparam logic [7:0] CRBDTH_TXPEND_OFS   = 8'h18;
	localparam logic [7:0] CRBDTH_STAT_OFS     = 8'h1C;
	localparam logic [7:0] CRBDTH_TXSEL_OFS    = 8'h20;
	localparam int         CRBDTH_HDR_BIT      = 7;
	localparam int         CRBDTH_CTRL_TXP     = 0;
	localparam int         CRBDTH_CTRL_GLOBAL_FD_OPERATION_ENABLE    = 1;
	localparam int         CRBDTH_CTRL_GLOBAL_RATE_SWITCH_ENABLE    = 2;
	localparam int         CRBDTH_HDR_FDF      = 29;
	localparam int         CRBDTH_HDR_BRS      = 30;
	localparam int         CRBDTH_CFG_SIZE_LSB = 16;
	localparam int         CRBDTH_STAT_IRQ     = 0;
	localparam int         CRBDTH_STAT_DMS_LSB = 1;
	localparam logic [2:0] CRBDTH_CODE_BUFFER  = 3'h7;
	localparam logic [1:0] CRBDTH_KIND_PLAIN   = 2'h0;
	localparam logic [1:0] CRBDTH_KIND_A       = 2'h1;
	localparam logic [1:0] CRBDTH_KIND_B       = 2'h2;
	localparam logic [1:0] CRBDTH_KIND_C       = 2'h3;
	localparam logic [1:0] CRBDTH_FMT_CLASSIC  = 2'h0;
	localparam logic [1:0] CRBDTH_FMT_FD       = 2'h1;
	localparam logic [1:0] CRBDTH_FMT_FD_BRS   = 2'h2;
	localparam logic [1:0] CRBDTH_PAUSE_BITS   = 2'h2;
	localparam logic [2:0] CRBDTH_CTRL_RST     = 3'h0;
	localparam logic [7:0][4:0] CRBDTH_ELEM_WORDS = {5'h12, 5'h0E, 5'h0A,
		5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
	localparam logic [7:0][6:0] CRBDTH_DATA_BYTES = {7'h40, 7'h30, 7'h20,
		7'h18, 7'h14, 7'h10, 7'h0C, 7'h08};

	typedef enum logic [1:0] {DBG_WAIT_A, DBG_GOT_A, DBG_GOT_B,
		DBG_DMA} crbdth_dbg_t;

	typedef struct packed {
		logic        req;
		logic [2:0]  code;
		logic [10:0] secondId;
	} crbdth_filt_t;

	typedef struct packed {
		logic        ack;
		logic        match;
		logic [15:0] addr;
	} crbdth_filt_resp_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  idx;
		logic [28:0] id;
		logic [1:0]  fmt;
		logic [15:0] addr;
	} crbdth_txsel_t;

	typedef struct packed {
		logic [63:0]       newData;
		logic              irqDrx;
		logic [2:0]        ctrl;
		logic [2:0]        rxSize;
		logic [15:0]       rbsa;
		logic [2:0]        txSize;
		logic [15:0]       tbsa;
		logic [31:0]       pending;
		logic [31:0][30:0] txHdr;
		crbdth_dbg_t       dbg;
		logic              scanning;
		logic [4:0]        scanIdx;
		logic              bestValid;
		logic [4:0]        bestIdx;
		logic [28:0]       bestId;
		crbdth_txsel_t     sel;
		logic [4:0]        actIdx;
		logic              pausing;
		logic [1:0]        pauseCnt;
		logic [31:0]       rdata;
		crbdth_filt_resp_t filt;
		logic              dmaReq;
	} crbdth_state_t;
endpackage

// >>> core/crbdth_handler.sv
/*
 * Dedicated rx buffer flags, debug message sequencer and tx handler.
 * Assumes the filter engine, RAM writer and protocol core run on the
 * same clock and talk in one-cycle pulses.
 */
// The address-and-strobe port and the placing of the registers are this design's own decisions.
// Summary of operation
// [RULE1] Last word stored sets buffer new-data flag
// [RULE2] Flagged buffer accepts no new frames
// [RULE3] Write one clears flag, zero keeps
// [RULE4] Element pointing to flagged buffer never matches
// [RULE5] Host clears irq, reads, then clears flags
// [RULE6] Code 111 stores at second-ID [5:0]
// [RULE7] Second-ID [10:9] picks debug A, B, C
// [RULE8] DMA request only after A, B, C
// [RULE9] During DMA request debug messages are rejected
// [RULE10] DMA acknowledge drops request, rearms sequencer
// [RULE11] Debug stores report status, not flags
// [RULE12] Out of order restarts, repeated A restarts
// [RULE13] Thirty-two tx buffers, per-buffer frame format
// [RULE14] Format from FD enable, FDF, BRS bits
// [RULE15] Pending change or start triggers lowest-ID scan
// [RULE16] Pause two idle bits after success
// [RULE17] Received frame end ends the pause
// [RULE18] Equal IDs: lowest buffer number wins
// [RULE19] Add request sets pending, core arbitrates
// [RULE20] Tx buffer at start plus index times size
// [RULE21] Size code maps to bytes and words
// [RULE22] Dedicated store also sets receive irq flag
// [RULE23] Host codes plain buffers as 111 and 00
`timescale 1ns/1ns
module crbdth_handler
	import crbdth_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              clkEn,
	input  wire logic [7:0]        regAddr,
	input  wire logic [31:0]       regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [31:0]       regRdata,
	input  wire crbdth_filt_t      filtReq,
	output crbdth_filt_resp_t      filtResp,
	input  wire logic              storeDone,
	input  wire logic [10:0]       storeSecondId,
	output logic                   dmaReq,
	input  wire logic              dmaAck,
	output crbdth_txsel_t          txSel,
	output logic                   dedicatedRxIrq,
	input  wire logic              txStart,
	input  wire logic              txDone,
	input  wire logic              rxFrameEnd,
	input  wire logic              bitTick,
	input  wire logic              busIdle
);
	crbdth_state_t st_reg;
	crbdth_state_t st_next;

	logic        wrHit;
	logic [5:0]  fIdx;
	logic [1:0]  fKind;
	logic [5:0]  sIdx;
	logic [1:0]  sKind;
	logic [31:0] pendNext;
	logic [28:0] candId;
	logic [30:0] bestHdr;
	logic [10:0] rxOfs;
	logic [10:0] txOfs;

	always_comb
	begin
		st_next = st_reg;
		wrHit = regWr && !regAddr[CRBDTH_HDR_BIT];
		fIdx = filtReq.secondId[5:0];
		fKind = filtReq.secondId[10:9];
		sIdx = storeSecondId[5:0];
		sKind = storeSecondId[10:9];
		candId = st_reg.txHdr[st_reg.scanIdx][28:0];
		bestHdr = st_reg.txHdr[st_reg.bestIdx];
		rxOfs = 11'(fIdx * CRBDTH_ELEM_WORDS[st_reg.rxSize]); // [RULE6]
		txOfs = 11'(st_reg.bestIdx
			* CRBDTH_ELEM_WORDS[st_reg.txSize]); // [RULE20] [RULE21]
		pendNext = st_reg.pending;

		// Register writes
		if (wrHit && regAddr == CRBDTH_NDAT_LO_OFS)
		begin
			st_next.newData[31:0] = st_reg.newData[31:0]
				& ~regWdata; // [RULE3]
		end
		else if (wrHit && regAddr == CRBDTH_NDAT_HI_OFS)
		begin
			st_next.newData[63:32] = st_reg.newData[63:32]
				& ~regWdata; // [RULE3]
		end
		else if (wrHit && regAddr == CRBDTH_CTRL_OFS)
		begin
			st_next.ctrl = regWdata[2:0];
		end
		else if (wrHit && regAddr == CRBDTH_RXCFG_OFS)
		begin
			st_next.rbsa = regWdata[15:0];
			st_next.rxSize = regWdata[CRBDTH_CFG_SIZE_LSB +: 3];
		end
		else if (wrHit && regAddr == CRBDTH_TXCFG_OFS)
		begin
			st_next.tbsa = regWdata[15:0];
			st_next.txSize = regWdata[CRBDTH_CFG_SIZE_LSB +: 3];
		end
		else if (wrHit && regAddr == CRBDTH_TXADD_OFS)
		begin
			pendNext = st_reg.pending | regWdata; // [RULE19]
		end
		else if (wrHit && regAddr == CRBDTH_STAT_OFS)
		begin
			if (regWdata[CRBDTH_STAT_IRQ])
			begin
				st_next.irqDrx = 1'b0;
			end
		end
		else if (regWr && regAddr[CRBDTH_HDR_BIT])
		begin
			st_next.txHdr[regAddr[6:2]] = regWdata[30:0]; // [RULE13]
		end

		// Register reads, data valid one cycle later
		st_next.rdata = 32'h0000_0000;
		if (regRd)
		begin
			if (regAddr[CRBDTH_HDR_BIT])
			begin
				st_next.rdata = {1'b0, st_reg.txHdr[regAddr[6:2]]};
			end
			else if (regAddr == CRBDTH_NDAT_LO_OFS)
			begin
				st_next.rdata = st_reg.newData[31:0];
			end
			else if (regAddr == CRBDTH_NDAT_HI_OFS)
			begin
				st_next.rdata = st_reg.newData[63:32];
			end
			else if (regAddr == CRBDTH_CTRL_OFS)
			begin
				st_next.rdata = {29'h0, st_reg.ctrl};
			end
			else if (regAddr == CRBDTH_RXCFG_OFS)
			begin
				st_next.rdata = {13'h0, st_reg.rxSize, st_reg.rbsa};
			end
			else if (regAddr == CRBDTH_TXCFG_OFS)
			begin
				st_next.rdata = {1'b0, CRBDTH_DATA_BYTES[st_reg.txSize],
					5'h00, st_reg.txSize, st_reg.tbsa}; // [RULE21]
			end
			else if (regAddr == CRBDTH_TXPEND_OFS)
			begin
				st_next.rdata = st_reg.pending;
			end
			else if (regAddr == CRBDTH_STAT_OFS)
			begin
				st_next.rdata = {29'h0, st_reg.dbg, st_reg.irqDrx}; // [RULE11]
			end
			else if (regAddr == CRBDTH_TXSEL_OFS)
			begin
				st_next.rdata = {st_reg.sel.valid, st_reg.pausing,
					st_reg.sel.fmt, 23'h0, st_reg.sel.idx};
			end
		end

		// Filter element evaluation, answered next cycle
		st_next.filt.ack = filtReq.req;
		st_next.filt.match = 1'b0;
		st_next.filt.addr = 16'(st_reg.rbsa + rxOfs); // [RULE6]
		if (filtReq.req && filtReq.code == CRBDTH_CODE_BUFFER)
		begin
			if (fKind == CRBDTH_KIND_PLAIN)
			begin
				st_next.filt.match = !st_reg.newData[fIdx]; // [RULE2] [RULE4] [RULE23]
			end
			else
			begin
				st_next.filt.match = st_reg.dbg != DBG_DMA; // [RULE9]
			end
		end

		// Completed stores: plain buffers flag, debug advances
		if (storeDone && sKind == CRBDTH_KIND_PLAIN)
		begin
			st_next.newData[sIdx] = 1'b1; // [RULE1]
			st_next.irqDrx = 1'b1; // [RULE22]
		end
		else if (storeDone && st_reg.dbg != DBG_DMA)
		begin
			case (sKind) // [RULE7]
				CRBDTH_KIND_A:
					st_next.dbg = DBG_GOT_A; // [RULE12]
				CRBDTH_KIND_B:
					st_next.dbg = (st_reg.dbg == DBG_GOT_A)
						? DBG_GOT_B : DBG_WAIT_A; // [RULE12]
				default:
					st_next.dbg = (st_reg.dbg == DBG_GOT_B)
						? DBG_DMA : DBG_WAIT_A; // [RULE8]
			endcase
		end
		if (st_reg.dbg == DBG_DMA && dmaAck)
		begin
			st_next.dbg = DBG_WAIT_A; // [RULE10]
		end
		st_next.dmaReq = st_next.dbg == DBG_DMA; // [RULE8] [RULE10]

		// Transmission lifecycle
		if (txStart)
		begin
			st_next.actIdx = st_reg.sel.idx;
		end
		if (txDone)
		begin
			pendNext[st_reg.actIdx] = 1'b0;
			if (st_reg.ctrl[CRBDTH_CTRL_TXP])
			begin
				st_next.pausing = 1'b1; // [RULE16]
				st_next.pauseCnt = 2'h0;
			end
		end
		else if (st_reg.pausing)
		begin
			if (rxFrameEnd)
			begin
				st_next.pausing = 1'b0; // [RULE17]
			end
			else if (bitTick && !busIdle)
			begin
				// Idle bits must be consecutive, so bus activity restarts
				st_next.pauseCnt = 2'h0; // [RULE16]
			end
			else if (bitTick)
			begin
				st_next.pauseCnt = st_reg.pauseCnt + 2'h1;
				if (st_reg.pauseCnt + 2'h1 == CRBDTH_PAUSE_BITS)
				begin
					st_next.pausing = 1'b0; // [RULE16]
				end
			end
		end
		st_next.pending = pendNext;

		// Serial priority scan, one buffer per cycle
		if (pendNext != st_reg.pending || txStart)
		begin
			st_next.scanning = 1'b1; // [RULE15]
			st_next.scanIdx = 5'h00;
			st_next.bestValid = 1'b0;
			st_next.sel.valid = 1'b0;
		end
		else if (st_reg.scanning)
		begin
			if (st_reg.pending[st_reg.scanIdx] && (!st_reg.bestValid
				|| candId < st_reg.bestId)) // [RULE15] [RULE18]
			begin
				st_next.bestValid = 1'b1;
				st_next.bestIdx = st_reg.scanIdx;
				st_next.bestId = candId;
			end
			st_next.scanIdx = st_reg.scanIdx + 5'h01;
			if (st_reg.scanIdx == 5'h1F)
			begin
				st_next.scanning = 1'b0;
			end
		end
		else
		begin
			// Publish the winner; pause only masks, never reorders
			st_next.sel.valid = st_reg.bestValid && !st_reg.pausing
				&& st_reg.pending[st_reg.bestIdx];
			st_next.sel.idx = st_reg.bestIdx;
			st_next.sel.id = st_reg.bestId;
			st_next.sel.addr = 16'(st_reg.tbsa + txOfs); // [RULE20]
			if (!st_reg.ctrl[CRBDTH_CTRL_GLOBAL_FD_OPERATION_ENABLE] || !bestHdr[CRBDTH_HDR_FDF])
			begin
				st_next.sel.fmt = CRBDTH_FMT_CLASSIC; // [RULE14]
			end
			else if (!st_reg.ctrl[CRBDTH_CTRL_GLOBAL_RATE_SWITCH_ENABLE]
				|| !bestHdr[CRBDTH_HDR_BRS])
			begin
				st_next.sel.fmt = CRBDTH_FMT_FD; // [RULE14]
			end
			else
			begin
				st_next.sel.fmt = CRBDTH_FMT_FD_BRS; // [RULE14]
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			st_reg <= '0;
			st_reg.ctrl <= CRBDTH_CTRL_RST; // [RULE16]
			st_reg.dbg <= DBG_WAIT_A;
		end
		else if (clkEn)
		begin
			st_reg <= st_next;
		end
	end

	assign regRdata = st_reg.rdata;
	assign filtResp = st_reg.filt;
	assign dmaReq = st_reg.dmaReq;
	assign txSel = st_reg.sel;
	assign dedicatedRxIrq = st_reg.irqDrx;
endmodule

// >>> test/crbdth_chk.sv
/* Port assertions for crbdth_handler.
   Bound to every instance; clkEn assumed high. */
`timescale 1ns/1ns
module crbdth_chk
	import crbdth_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              nrst,
	input wire crbdth_filt_t      filtReq,
	input wire crbdth_filt_resp_t filtResp,
	input wire logic              storeDone,
	input wire logic [10:0]       storeSecondId,
	input wire logic              dmaReq,
	input wire logic              dmaAck,
	input wire crbdth_txsel_t     txSel,
	input wire logic              dedicatedRxIrq,
	input wire logic              txStart
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic cStore;
	logic dbgFilt;
	assign cStore = storeDone && storeSecondId[10:9] == 2'h3;
	assign dbgFilt = filtReq.req && filtReq.code == CRBDTH_CODE_BUFFER
		&& filtReq.secondId[10:9] != 2'h0;
	sequence rescanS;
		!txSel.valid [*4];
	endsequence
	sequence dropS;
		##[1:2] !dmaReq;
	endsequence
	a_filt_ack: assert property (filtReq.req |=> filtResp.ack)
		else $error("filter request not answered");
	a_code_other: assert property (filtReq.req
		&& filtReq.code != CRBDTH_CODE_BUFFER |=> !filtResp.match)
		else $error("non buffer code matched");
	a_dbg_reject: assert property (dbgFilt && dmaReq && !dmaAck
		&& !$past(dmaAck) |=> !filtResp.match)
		else $error("debug accepted during dma");
	a_dma_cause: assert property ($rose(dmaReq)
		|-> $past(cStore) || $past(cStore, 2))
		else $error("dma request without message c");
	a_ack_drop: assert property (dmaReq && dmaAck |-> dropS)
		else $error("dma request held after ack");
	a_dbg_noirq: assert property (storeDone && !dedicatedRxIrq
		&& storeSecondId[10:9] != 2'h0 |=> !dedicatedRxIrq)
		else $error("debug store raised irq");
	a_plain_irq: assert property (storeDone
		&& storeSecondId[10:9] == 2'h0 |=> dedicatedRxIrq)
		else $error("buffer store left irq low");
	a_start_scan: assert property (txStart |=> rescanS)
		else $error("no rescan after start");
	a_fmt_legal: assert property (txSel.valid |-> txSel.fmt != 2'h3)
		else $error("illegal frame format");
	a_sel_stable: assert property (txSel.valid
		&& $past(txSel.valid) |-> $stable(txSel.idx))
		else $error("selection changed while valid");
endmodule
bind crbdth_handler crbdth_chk i_chk (.core_clk(core_clk), .nrst(nrst),
	.filtReq(filtReq), .filtResp(filtResp), .storeDone(storeDone),
	.storeSecondId(storeSecondId), .dmaReq(dmaReq), .dmaAck(dmaAck),
	.txSel(txSel), .dedicatedRxIrq(dedicatedRxIrq), .txStart(txStart));

// >>> test/crbdth_dma_model.sv
/* DMA unit model: acks a debug request lat+1 cycles after it rises.
   Ack stays high until the request drops. */
`timescale 1ns/1ns
module crbdth_dma_model
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic [7:0] lat,
	input  wire logic       dmaReq,
	output logic            dmaAck
);
	logic [7:0] cnt_reg;
	always_ff @(posedge core_clk)
	begin
		if (!nrst || !dmaReq)
		begin
			cnt_reg <= 8'h00;
			dmaAck  <= 1'h0;
		end
		else if (cnt_reg == lat)
			dmaAck <= 1'h1; // Reads done, ack until drop
		else
			cnt_reg <= cnt_reg + 8'h01;
	end
endmodule

// >>> test/crbdth_handler_tb.sv
/* Self-checking bench for crbdth_handler.
   Needs the DMA model; clkEn held high throughout. */
`timescale 1ns/1ns
module crbdth_handler_tb
	import crbdth_pkg::*;
;
	logic              core_clk = 1'h0;
	logic              nrst = 1'h0;
	logic [7:0]        regAddr = 8'h00;
	logic [31:0]       regWdata = 32'h0;
	logic [31:0]       regRdata;
	logic              regWr = 1'h0;
	logic              regRd = 1'h0;
	logic              storeDone = 1'h0;
	logic [10:0]       storeSecondId = 11'h000;
	crbdth_filt_t      filtReq = '0;
	crbdth_filt_resp_t filtResp;
	crbdth_txsel_t     txSel;
	logic              dmaReq, dmaAck, dedicatedRxIrq;
	logic              txStart = 1'h0;
	logic              txDone = 1'h0;
	logic              rxFrameEnd = 1'h0;
	logic              bitTick = 1'h0;
	logic              busIdle = 1'h1;
	int                badCount = 0;
	int                nCompared = 0;
	always #5 core_clk = ~core_clk;
	crbdth_handler i_dut (.core_clk(core_clk), .nrst(nrst), .clkEn(1'h1),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .filtReq(filtReq),
		.filtResp(filtResp), .storeDone(storeDone),
		.storeSecondId(storeSecondId), .dmaReq(dmaReq), .dmaAck(dmaAck),
		.txSel(txSel), .dedicatedRxIrq(dedicatedRxIrq), .txStart(txStart),
		.txDone(txDone), .rxFrameEnd(rxFrameEnd), .bitTick(bitTick),
		.busIdle(busIdle));
	crbdth_dma_model i_dma (.core_clk(core_clk), .nrst(nrst), .lat(8'h14),
		.dmaReq(dmaReq), .dmaAck(dmaAck));
	task automatic stopTest();
		$display("Compared %0d, mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		nCompared++;
		if (g !== e)
		begin
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
			badCount++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regWr    <= 1'h1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		regRd   <= 1'h1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'h0;
		#1 chk(regRdata, e);
	endtask
	task automatic st(input logic [10:0] s);
		@(posedge core_clk);
		storeDone     <= 1'h1;
		storeSecondId <= s;
		@(posedge core_clk);
		storeDone <= 1'h0;
	endtask
	task automatic filt(input logic [2:0] c, input logic [10:0] s,
		input logic m);
		@(posedge core_clk);
		filtReq <= {1'h1, c, s};
		@(posedge core_clk);
		filtReq.req <= 1'h0;
		#1 chk(32'({filtResp.ack, filtResp.match}), 32'({1'h1, m}));
	endtask
	task automatic go();
		@(posedge core_clk);
		txStart <= 1'h1;
		@(posedge core_clk);
		txStart <= 1'h0;
		repeat (2) @(posedge core_clk);
		txDone <= 1'h1;
		@(posedge core_clk);
		txDone <= 1'h0;
	endtask
	task automatic pulse(input bit frameEnd, input bit busy);
		@(posedge core_clk);
		if (frameEnd)
			rxFrameEnd <= 1'h1;
		else
			bitTick <= 1'h1;
		busIdle <= !busy;
		@(posedge core_clk);
		rxFrameEnd <= 1'h0;
		bitTick    <= 1'h0;
		busIdle    <= 1'h1;
	endtask
	// Bounded wait for a published selection
	task automatic wsel(input logic [4:0] i, input logic [1:0] f);
		int n;
		n = 0;
		repeat (3) @(posedge core_clk);
		// Off the edge, so a selection dropping there is not missed
		#1;
		while (txSel.valid !== 1'h1 && n < 100)
		begin
			@(posedge core_clk);
			#1 n++;
		end
		chk(32'({txSel.valid, txSel.fmt, txSel.idx}), 32'({1'h1, f, i}));
		if (n >= 100)
			stopTest();
	endtask
	task automatic tRxBuf();
		wr(CRBDTH_RXCFG_OFS, 32'h0001_0100);
		filt(3'h7, 11'h005, 1'h1);
		chk(32'(filtResp.addr), 32'h0119);
		filt(3'h1, 11'h005, 1'h0);
		st(11'h005);
		rd(CRBDTH_STAT_OFS, 32'h1);
		wr(CRBDTH_STAT_OFS, 32'h1);
		rd(CRBDTH_NDAT_LO_OFS, 32'h20);
		filt(3'h7, 11'h005, 1'h0);
		wr(CRBDTH_NDAT_LO_OFS, 32'h0);
		rd(CRBDTH_NDAT_LO_OFS, 32'h20);
		wr(CRBDTH_NDAT_LO_OFS, 32'h20);
		rd(CRBDTH_NDAT_LO_OFS, 32'h0);
		st(11'h021);
		rd(CRBDTH_NDAT_HI_OFS, 32'h2);
		wr(CRBDTH_NDAT_HI_OFS, 32'h2);
		wr(CRBDTH_STAT_OFS, 32'h1);
	endtask
	task automatic tDebug();
		st(11'h23D);
		st(11'h63F);
		rd(CRBDTH_STAT_OFS, 32'h0);
		st(11'h23D);
		st(11'h23D);
		st(11'h43E);
		rd(CRBDTH_STAT_OFS, 32'h4);
		st(11'h63F);
		rd(CRBDTH_STAT_OFS, 32'h6);
		chk(32'(dmaReq), 32'h1);
		filt(3'h7, 11'h23D, 1'h0);
		st(11'h23D);
		rd(CRBDTH_STAT_OFS, 32'h6);
		rd(CRBDTH_NDAT_HI_OFS, 32'h0);
		repeat (40) @(posedge core_clk);
		#1 chk(32'(dmaReq), 32'h0);
		rd(CRBDTH_STAT_OFS, 32'h0);
	endtask
	task automatic tTx();
		wr(CRBDTH_CTRL_OFS, 32'h6);
		wr(8'h84, 32'h2000_0010);
		wr(8'h8C, 32'h6000_0010);
		wr(8'h9C, 32'h4000_0020);
		wr(CRBDTH_TXCFG_OFS, 32'h0007_0200);
		rd(CRBDTH_TXCFG_OFS, 32'h4007_0200);
		wr(CRBDTH_TXADD_OFS, 32'h8A);
		rd(CRBDTH_TXPEND_OFS, 32'h8A);
		wsel(5'h01, CRBDTH_FMT_FD);
		chk(32'(txSel.addr), 32'h0212);
		chk(32'(txSel.id), 32'h0000_0010);
		go();
		rd(CRBDTH_TXPEND_OFS, 32'h88);
		wsel(5'h03, CRBDTH_FMT_FD_BRS);
		chk(32'(txSel.addr), 32'h0236);
		wr(CRBDTH_CTRL_OFS, 32'h7);
		go();
		repeat (40) @(posedge core_clk);
		#1 chk(32'(txSel.valid), 32'h0);
		rd(CRBDTH_TXSEL_OFS, 32'h4000_0007);
		pulse(1'b1, 1'b0);
		wsel(5'h07, CRBDTH_FMT_CLASSIC);
		wr(CRBDTH_TXADD_OFS, 32'h08);
		wsel(5'h03, CRBDTH_FMT_FD_BRS);
		go();
		pulse(1'b0, 1'b0);
		// Busy bit must restart the idle count
		pulse(1'b0, 1'b1);
		pulse(1'b0, 1'b0);
		repeat (40) @(posedge core_clk);
		#1 chk(32'(txSel.valid), 32'h0);
		pulse(1'b0, 1'b0);
		wsel(5'h07, CRBDTH_FMT_CLASSIC);
		wr(CRBDTH_CTRL_OFS, 32'h2);
		wr(CRBDTH_TXADD_OFS, 32'h08);
		wsel(5'h03, CRBDTH_FMT_FD);
		wr(CRBDTH_CTRL_OFS, 32'h0);
		wr(CRBDTH_TXADD_OFS, 32'h02);
		wsel(5'h01, CRBDTH_FMT_CLASSIC);
	endtask
	initial
	begin
		repeat (20000) @(posedge core_clk);
		badCount++;
		stopTest();
	end
	initial
	begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'h1;
		rd(CRBDTH_CTRL_OFS, 32'h0);
		rd(8'hF0, 32'h0);
		tRxBuf();
		tDebug();
		tTx();
		stopTest();
	end
endmodule
